// ===== logic/rivg_vector_gen.sv
// Reset and interrupt vector address generator for the fetch unit.
//----------------------------------------------------------------------
// Overview of operation
// - Twenty-two slots two words apart, last 0x002A.
// - All reset sources share one reset vector, 0x0000 with the fuse unprogrammed.
// - Ext irq zero and pin changes at 0x0002-0x0006.
// - Timer 2 and timer 1 vectors 0x0008-0x0012.
// - Timer 0, serial vectors 0x0014-0x001E.
// - Serial iface, comparator, converter, nvm 0x0020-0x002A.
// - Programmed fuse starts reset at boot start.
// - Select set adds boot start to vectors.
// - Table base independent of reset address choice.
// - Fuse one unprogrammed, zero programmed.
// - Enable clears after four cycles or select write.
// - Block interrupts during move, flag untouched.
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "rivg_defs.svh"

module rivg_vector_gen #(
   parameter int ADDR_W  = 16,
   parameter int NUM_VEC = `RIVG_NUM_VEC
) (
   // Clock and reset.
   input  wire logic              sys_clk,
   input  wire logic              arst_n,
   // Reset sources: pin, power-on, brown-out, watchdog, debug port.
   input  wire logic [4:0]        reset_src,
   // Fuses and boot section placement.
   input  wire logic              boot_reset_fuse,
   input  wire logic [ADDR_W-1:0] boot_start_addr,
   // Core control register write and instruction retire.
   input  wire logic              ctl_wr,
   input  wire logic [1:0]        ctl_wdata,
   input  wire logic              instr_done,
   // Interrupt requests, bit 0 is vector 2.
   input  wire logic [NUM_VEC-2:0] irq_req,
   input  wire logic              global_irq_en,
   // Fetch side results.
   output logic                   reset_active,
   output logic [ADDR_W-1:0]      reset_addr,
   output logic                   irq_pending,
   output logic [4:0]             vector_no,
   output logic [ADDR_W-1:0]      vector_addr,
   // Control state seen by the core.
   output logic                   vector_table_select,
   output logic                   vector_change_enable,
   output logic                   irq_blocked
);

   localparam int NUM_IRQ = NUM_VEC - 1;

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   if (NUM_VEC != `RIVG_NUM_VEC || ADDR_W < 7 || ADDR_W > 16) begin : g_chk
      $error("rivg_vector_gen: unsupported NUM_VEC or ADDR_W");
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic                 reset_active_reg;
   logic [ADDR_W-1:0]    reset_addr_reg;
   logic                 irq_pending_reg;
   logic [4:0]           vector_no_reg;
   logic [ADDR_W-1:0]    vector_addr_reg;
   logic                 sel_reg;
   logic                 chg_en_reg;
   logic                 chg_en_next;
   logic                 blocked_reg;
   logic [1:0]           cnt_reg;
   logic [1:0]           cnt_next;
   rivg_pkg::rivg_blk_e  blk_reg;
   rivg_pkg::rivg_blk_e  blk_next;
   logic                 any_reset;
   logic                 en_wr;
   logic                 sel_wr;
   logic                 blocked_next;
   logic [NUM_IRQ-1:0]   req_ok;
   logic [NUM_IRQ-1:0]   grant;
   logic [4:0]           sel_idx;
   logic [15:0]          sel_ofs;
   logic [ADDR_W-1:0]    table_base;

   assign any_reset = |reset_src;
   // A write with the enable bit set only arms; it never moves the table.
   assign en_wr     = ctl_wr & ctl_wdata[`RIVG_CTL_EN_BIT];
   assign sel_wr    = ctl_wr & ~ctl_wdata[`RIVG_CTL_EN_BIT] & chg_en_reg;

   // ---------------------------------------------------------------
   // Reset vector
   // ---------------------------------------------------------------
   // Every reset source lands on the same vector; the fuse picks its place.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reset_active_reg <= 1'b1;
         reset_addr_reg   <= ADDR_W'(`RIVG_RESET_OFS);
      end else begin
         reset_active_reg <= any_reset;
         if (boot_reset_fuse == `RIVG_FUSE_PROG) begin
            reset_addr_reg <= boot_start_addr;
         end else begin
            reset_addr_reg <= ADDR_W'(`RIVG_RESET_OFS);
         end
      end
   end

   // ---------------------------------------------------------------
   // Change window and block state
   // ---------------------------------------------------------------
   // The block starts in the very cycle the enable is written, so a request
   // arriving with that write cannot slip through.
   always_comb begin
      blk_next    = blk_reg;
      cnt_next    = cnt_reg;
      chg_en_next = chg_en_reg;
      case (blk_reg)
         rivg_pkg::RIVG_BLK_IDLE: begin
            if (en_wr) begin
               blk_next = rivg_pkg::RIVG_BLK_ARMED;
            end
         end
         rivg_pkg::RIVG_BLK_ARMED: begin
            if (sel_wr) begin
               blk_next = rivg_pkg::RIVG_BLK_AFTER_WR;
            end else if (!en_wr && cnt_reg == 2'h0) begin
               blk_next = rivg_pkg::RIVG_BLK_IDLE;
            end
         end
         rivg_pkg::RIVG_BLK_AFTER_WR: begin
            if (en_wr) begin
               blk_next = rivg_pkg::RIVG_BLK_ARMED;
            end else if (instr_done) begin
               blk_next = rivg_pkg::RIVG_BLK_IDLE;
            end
         end
         default: begin
            blk_next = rivg_pkg::RIVG_BLK_IDLE;
         end
      endcase
      if (en_wr) begin
         chg_en_next = 1'b1;
         cnt_next    = 2'(`RIVG_CHG_WIN_CYC - 1);
      end else if (sel_wr) begin
         chg_en_next = 1'b0;
      end else if (chg_en_reg) begin
         if (cnt_reg == 2'h0) begin
            chg_en_next = 1'b0;
         end else begin
            cnt_next = cnt_reg - 2'h1;
         end
      end
      if (any_reset) begin
         blk_next    = rivg_pkg::RIVG_BLK_IDLE;
         chg_en_next = 1'b0;
         cnt_next    = 2'h0;
      end
      blocked_next = (blk_next != rivg_pkg::RIVG_BLK_IDLE);
   end

   // Window state.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         blk_reg     <= rivg_pkg::RIVG_BLK_IDLE;
         cnt_reg     <= 2'h0;
         chg_en_reg  <= 1'b0;
         blocked_reg <= 1'b0;
      end else begin
         blk_reg     <= blk_next;
         cnt_reg     <= cnt_next;
         chg_en_reg  <= chg_en_next;
         blocked_reg <= blocked_next;
      end
   end

   // Table select; only a write inside the open window or a reset changes it.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_reg <= `RIVG_SEL_RST;
      end else if (any_reset) begin
         sel_reg <= `RIVG_SEL_RST;
      end else if (sel_wr) begin
         sel_reg <= ctl_wdata[`RIVG_CTL_SEL_BIT];
      end
   end

   // ---------------------------------------------------------------
   // Request arbitration
   // ---------------------------------------------------------------
   // The global flag is only read here, never altered by the block.
   assign req_ok = irq_req & {NUM_IRQ{global_irq_en & ~blocked_next}};

   // Each request wins only if no lower-numbered request is present.
   for (genvar i = 0; i < NUM_IRQ; i++) begin : g_grant
      if (i == 0) begin : g_first
         assign grant[i] = req_ok[i];
      end else begin : g_rest
         assign grant[i] = req_ok[i] & ~(|req_ok[i-1:0]);
      end
   end

   // One-hot grant to slot index.
   always_comb begin
      sel_idx = 5'h00;
      for (int k = 0; k < NUM_IRQ; k++) begin
         if (grant[k]) begin
            sel_idx = sel_idx | 5'(k);
         end
      end
   end

   // Slot k sits one stride above slot k-1 from the first interrupt slot.
   assign sel_ofs    = `RIVG_TABLE_OFS + `RIVG_SLOT_STRIDE * 16'(sel_idx);
   assign table_base = sel_reg ? boot_start_addr : ADDR_W'(`RIVG_RESET_OFS);

   // Registered vector; the adder wraps inside the program space.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_pending_reg <= 1'b0;
         vector_no_reg   <= 5'h00;
         vector_addr_reg <= ADDR_W'(`RIVG_TABLE_OFS);
      end else begin
         irq_pending_reg <= |req_ok & ~any_reset;
         vector_no_reg   <= sel_idx + 5'h02;
         vector_addr_reg <= table_base + ADDR_W'(sel_ofs);
      end
   end

   assign reset_active         = reset_active_reg;
   assign reset_addr           = reset_addr_reg;
   assign irq_pending          = irq_pending_reg;
   assign vector_no            = vector_no_reg;
   assign vector_addr          = vector_addr_reg;
   assign vector_table_select  = sel_reg;
   assign vector_change_enable = chg_en_reg;
   assign irq_blocked          = blocked_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   a_reset_route: assert property (any_reset |=> reset_active && !irq_pending)
      else $error("reset source did not reach reset vector");
   a_fuse_addr: assert property (##1 reset_addr ==
      ($past(boot_reset_fuse) ? ADDR_W'(16'h0000) : $past(boot_start_addr)))
      else $error("reset address does not follow boot fuse");
   a_first_slot: assert property ($past(req_ok[0]) |-> vector_no == 5'h02 &&
      vector_addr == $past(table_base) + ADDR_W'(16'h0002))
      else $error("first interrupt slot wrong");
   a_last_slot: assert property (($past(grant[NUM_IRQ-1]) && !$past(sel_reg))
      |-> vector_addr == ADDR_W'(16'h002a) && vector_no == 5'd22)
      else $error("last slot not at 0x002A");
   a_boot_table: assert property ($past(sel_reg) && irq_pending
      |-> vector_addr == $past(boot_start_addr) + ADDR_W'(16'h0002)
          + ADDR_W'(16'h0002) * ADDR_W'(vector_no - 5'h02))
      else $error("boot table address wrong");
   a_lowest_wins: assert property ($past(req_ok[0] && req_ok[1]) |->
      vector_no == 5'h02)
      else $error("lower vector lost arbitration");
   a_enable_life: assert property (en_wr ##1 (!en_wr)[*4] |=>
      !vector_change_enable)
      else $error("change enable outlived four cycles");
   a_sel_guard: assert property (!$stable(vector_table_select) && !$past(any_reset)
      |-> $past(vector_change_enable && ctl_wr))
      else $error("select changed without window");
   a_block_cover: assert property (vector_change_enable |-> irq_blocked &&
      !irq_pending)
      else $error("interrupt accepted during table move");
   a_block_after_wr: assert property (sel_wr |=> irq_blocked until_with
      (instr_done || any_reset))
      else $error("block released before next instruction");

   c_table_move: cover property (sel_wr && ctl_wdata[`RIVG_CTL_SEL_BIT]);
   c_window_lapse: cover property (vector_change_enable[*4] ##1 !vector_change_enable);
   c_two_requests: cover property (req_ok[0] && req_ok[NUM_IRQ-1]);
   c_boot_reset: cover property (reset_active && !boot_reset_fuse);

endmodule : rivg_vector_gen

// ===== pkg/rivg_defs.svh
// Constants for the reset and interrupt vector address generator.
`ifndef RIVG_DEFS_SVH
`define RIVG_DEFS_SVH

// ----------------------------------------------------------------------
// Vector table layout, in program words
// ----------------------------------------------------------------------
`define RIVG_NUM_VEC        22
`define RIVG_RESET_OFS      16'h0000
`define RIVG_TABLE_OFS      16'h0002
`define RIVG_LAST_OFS       16'h002a
`define RIVG_SLOT_STRIDE    16'h0002

// ----------------------------------------------------------------------
// Control word fields and reset values
// ----------------------------------------------------------------------
`define RIVG_CTL_EN_BIT     0
`define RIVG_CTL_SEL_BIT    1
`define RIVG_SEL_RST        1'b0
`define RIVG_FUSE_PROG      1'b0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RIVG_CHG_WIN_CYC    4

`endif

// ===== pkg/rivg_pkg.sv
// Types shared by the reset and interrupt vector address generator.
package rivg_pkg;

   // State of the automatic interrupt block around a table move.
   typedef enum logic [1:0] {
      RIVG_BLK_IDLE,
      RIVG_BLK_ARMED,
      RIVG_BLK_AFTER_WR
   } rivg_blk_e;

   // Vector number, 1 is reset.
   typedef logic [4:0] rivg_vecno_t;

endpackage : rivg_pkg

// ===== sim/rivg_core_model.sv
// Behavioural model of the core's interrupt acceptance for the vector generator bench.
`timescale 1ns/1ps
//----------------------------------------------------------------------
// Core acceptance model
//----------------------------------------------------------------------
module rivg_core_model (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // Bench control: new requests and acceptance delay in cycles.
   input  wire logic [20:0] raise,
   input  wire logic [3:0]  lat,
   // Generator results seen by the core.
   input  wire logic        irq_pending,
   input  wire logic [4:0]  vector_no,
   // Request lines towards the generator.
   output logic      [20:0] irq_req
);
   logic [3:0] wait_reg;

   // A source stays up until the core has taken its vector, like a peripheral flag.
   // A slow core leaves it pending for lat cycles, so lower-priority requests wait too.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_req  <= 21'h000000;
         wait_reg <= 4'h0;
      end else if (irq_pending && wait_reg == lat) begin
         irq_req  <= (irq_req | raise) & ~(21'h000001 << (vector_no - 5'h02));
         wait_reg <= 4'h0;
      end else begin
         irq_req  <= irq_req | raise;
         wait_reg <= irq_pending ? wait_reg + 4'h1 : 4'h0;
      end
   end
endmodule : rivg_core_model

// ===== sim/test_reset_irq_vector_address_gen.sv
// Self-checking bench for the reset and interrupt vector address generator.
`timescale 1ns/1ps
`include "rivg_defs.svh"
module test_reset_irq_vector_address_gen;
   localparam logic [15:0] BOOT = 16'h1c00;
   logic        sys_clk, arst_n, boot_reset_fuse, ctl_wr, instr_done, global_irq_en;
   logic        reset_active, irq_pending, vector_table_select, vector_change_enable, irq_blocked;
   logic [4:0]  reset_src, vector_no;
   logic [1:0]  ctl_wdata;
   logic [3:0]  lat;
   logic [15:0] reset_addr, vector_addr;
   logic [20:0] raise, irq_req;
   int          err_count, samples_checked;
   //----------------------------------------------------------------------
   // Design and core model
   //----------------------------------------------------------------------
   rivg_vector_gen dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .reset_src(reset_src),
      .boot_reset_fuse(boot_reset_fuse), .boot_start_addr(BOOT), .ctl_wr(ctl_wr),
      .ctl_wdata(ctl_wdata), .instr_done(instr_done), .irq_req(irq_req),
      .global_irq_en(global_irq_en), .reset_active(reset_active), .reset_addr(reset_addr),
      .irq_pending(irq_pending), .vector_no(vector_no), .vector_addr(vector_addr),
      .vector_table_select(vector_table_select), .vector_change_enable(vector_change_enable),
      .irq_blocked(irq_blocked));
   rivg_core_model core_u (.sys_clk(sys_clk), .arst_n(arst_n), .raise(raise), .lat(lat),
      .irq_pending(irq_pending), .vector_no(vector_no), .irq_req(irq_req));
   //----------------------------------------------------------------------
   // Helpers: every drive and every look happens 1 ns after a rising edge.
   //----------------------------------------------------------------------
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // One-cycle control write; returns in the cycle its result is visible.
   task ctl(input logic [1:0] d);
      ctl_wr = 1'b1;
      ctl_wdata = d;
      tick(1);
      ctl_wr = 1'b0;
   endtask : ctl
   // Raise one source; returns once the generator has sampled it.
   task pulse_irq(input int k);
      raise = 21'h000001 << k;
      tick(1);
      raise = 21'h000000;
      tick(1);
   endtask : pulse_irq
   task wait_idle();
      for (int i = 0; i < 40 && irq_pending !== 1'b0; i++) tick(1);
      chk("irq_pending idle", {15'h0000, irq_pending}, 16'h0000);
   endtask : wait_idle
   //----------------------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------------------
   task t_reset_sources();
      for (int f = 1; f >= 0; f--) for (int s = 0; s < 5; s++) begin
         boot_reset_fuse = f[0];
         reset_src = 5'h01 << s;
         tick(1);
         chk("reset_active", {15'h0000, reset_active}, 16'h0001);
         chk("reset_addr", reset_addr, f ? `RIVG_RESET_OFS : BOOT);
         reset_src = 5'h00;
         tick(1);
         chk("reset_active off", {15'h0000, reset_active}, 16'h0000);
      end
   endtask : t_reset_sources
   task t_all_vectors();
      lat = 4'h0;
      for (int k = 0; k < 21; k++) begin
         pulse_irq(k);
         chk("vector_no", {11'h000, vector_no}, 16'(k + 2));
         chk("vector_addr", vector_addr, 16'(`RIVG_TABLE_OFS + k * `RIVG_SLOT_STRIDE));
         wait_idle();
      end
   endtask : t_all_vectors
   // Three requests held back by the global flag, then served lowest number first.
   task t_priority();
      global_irq_en = 1'b0;
      lat = 4'h3;
      raise = 21'h00000b;
      tick(1);
      raise = 21'h000000;
      tick(2);
      chk("pending flag low", {15'h0000, irq_pending}, 16'h0000);
      global_irq_en = 1'b1;
      tick(1);
      chk("first winner", {11'h000, vector_no}, 16'h0002);
      for (int i = 0; i < 20 && vector_no === 5'h02; i++) tick(1);
      chk("second winner", {11'h000, vector_no}, 16'h0003);
      chk("second addr", vector_addr, 16'h0004);
      for (int i = 0; i < 20 && vector_no === 5'h03; i++) tick(1);
      chk("third winner", {11'h000, vector_no}, 16'h0005);
      chk("third addr", vector_addr, 16'h0008);
      wait_idle();
   endtask : t_priority
   // Enable written and left to expire: four blocked cycles, flag untouched.
   task t_window_timeout();
      lat = 4'hf;
      pulse_irq(2);
      chk("pending before", {15'h0000, irq_pending}, 16'h0001);
      ctl(2'b01);
      for (int i = 0; i < 4; i++) begin
         chk("window", {13'h0000, vector_change_enable, irq_blocked, irq_pending}, 16'h0006);
         tick(1);
      end
      chk("window closed", {14'h0000, vector_change_enable, irq_blocked}, 16'h0000);
      tick(1);
      chk("pending after", {15'h0000, irq_pending}, 16'h0001);
   endtask : t_window_timeout
   // Table moved into the boot section, stray write refused, reset clears the move.
   task t_move();
      boot_reset_fuse = 1'b1;
      ctl(2'b01);
      tick(1);
      ctl(2'b10);
      chk("select set", {13'h0000, vector_table_select, vector_change_enable, irq_blocked},
          16'h0005);
      instr_done = 1'b1;
      tick(1);
      instr_done = 1'b0;
      chk("block ends", {15'h0000, irq_blocked}, 16'h0000);
      tick(1);
      chk("moved addr", vector_addr, BOOT + 16'h0006);
      ctl(2'b00);
      tick(1);
      chk("stray write", {15'h0000, vector_table_select}, 16'h0001);
      reset_src = 5'h08;
      tick(1);
      reset_src = 5'h00;
      chk("reset addr moved", reset_addr, `RIVG_RESET_OFS);
      tick(1);
      chk("select cleared", {15'h0000, vector_table_select}, `RIVG_SEL_RST);
      lat = 4'h0;
      wait_idle();
   endtask : t_move
   //----------------------------------------------------------------------
   // Clock, watchdog, sequence and verdict
   //----------------------------------------------------------------------
   task report_and_stop();
      $display("Checks %0d, errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // The scenarios need well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge sys_clk);
      err_count++;
      report_and_stop();
   end
   initial begin
      {arst_n, ctl_wr, instr_done, raise, reset_src, ctl_wdata} = '0;
      {boot_reset_fuse, global_irq_en, lat} = {2'b11, 4'h0};
      err_count = 0;
      samples_checked = 0;
      repeat (12) @(posedge sys_clk);
      // Held in reset: only reset_active is up, the vector points at the first slot.
      #1 chk("reset state", {6'h00, reset_active, vector_no, irq_pending, vector_change_enable,
          vector_table_select, irq_blocked}, 16'h0200);
      chk("reset vector", vector_addr, `RIVG_TABLE_OFS);
      chk("reset addr idle", reset_addr, `RIVG_RESET_OFS);
      arst_n = 1'b1;
      tick(1);
      t_reset_sources();
      t_all_vectors();
      t_priority();
      t_window_timeout();
      t_move();
      report_and_stop();
   end
endmodule : test_reset_irq_vector_address_gen
